// ---- verilog/pcisig_dev.sv ----
// nic end of the pci signalling: master, target, parity, interrupt and pme
`timescale 1ns/1ps
`include "pcisig_consts.svh"
module pcisig_dev (
   input  wire logic                          clk,           // pci clock
   input  wire logic                          rst_b,         // sync reset, low active
   pcisig_if.dev                              bus,           // pci wires
   input  wire logic                          mst_start,     // pulse: begin master cycle
   input  wire logic                          mst_write,     // master direction
   input  wire logic [31:0]                   mst_addr,      // master address
   input  wire logic [31:0]                   mst_wdata,     // master write data
   input  wire logic                          mst_ready,     // user ready for data phase
   input  wire logic [`PCISIG_INT_WIDTH-1:0]  status_set,    // network status events
   input  wire logic [`PCISIG_INT_WIDTH-1:0]  status_clr,    // software clears
   input  wire logic [`PCISIG_INT_WIDTH-1:0]  int_mask,      // interrupt mask bits
   input  wire logic                          pme_event,     // power event level
   output logic                               mst_done,      // pulse: master cycle ended
   output logic                               mst_abort,     // pulse: no target/stopped
   output logic [31:0]                        mst_rdata,     // ad at last master data phase, read or write
   output logic [`PCISIG_INT_WIDTH-1:0]       status_q_o     // network status view
);
   // state and registers
   pcisig_pkg::pcisig_state_type st_q, st_d;
   logic [31:0] ad_o_q, ad_o_d;             // ad drive value
   logic        ad_oe_q, ad_oe_d;           // ad enable
   logic [3:0]  cbe_q, cbe_d;               // command/byte enable drive
   logic        frame_q, frame_d, irdy_q, irdy_d, trdy_q, trdy_d;
   logic        devsel_q, devsel_d, mctl_oe_q, mctl_oe_d, tctl_oe_q, tctl_oe_d;
   logic        par_oe_q, par_oe_d, par_q, par_d;
   logic        perr_q, perr_d, serr_q, serr_d, sp_q, sp_d;
   logic        chkd_q, chkd_d, chkaddr_q, chkaddr_d; // parity check pending
   logic [31:0] cs_q, cs_d, bar_q, bar_d;   // pci command/status, base address
   logic [5:0]  cidx_q, cidx_d;             // config register index
   logic        tcfg_q, tcfg_d, twr_q, twr_d;
   logic        req_q, req_d, done_q, done_d, abort_q, abort_d;
   logic [31:0] rdata_q, rdata_d;
   logic [2:0]  dcnt_q, dcnt_d;             // devsel wait counter
   logic [`PCISIG_INT_WIDTH-1:0] ns_q, ns_d;
   logic        int_q, int_d, pme_q, pme_d;
   logic [31:0] ad_prev_q;                  // ad as sampled one clock ago
   logic [3:0]  cbe_prev_q;                 // c/be as sampled one clock ago
   logic        pme_s1_q, pme_s2_q;         // pme synchroniser
   logic [31:0] in_ad;
   logic [3:0]  in_cbe;
   logic        in_par, dphase;

   // even parity over ad and c/be
   function automatic logic even_par(input logic [31:0] a, input logic [3:0] c);
      even_par = ^{a, c};
   endfunction

   assign in_ad  = bus.ad;
   assign in_cbe = bus.cbe_b;
   assign in_par = bus.par;
   assign dphase = !bus.irdy_b && !bus.trdy_b;

   // bus state machine and parity next values
   always_comb begin
      st_d = st_q; ad_o_d = ad_o_q; ad_oe_d = ad_oe_q; cbe_d = cbe_q;
      frame_d = frame_q; irdy_d = irdy_q; trdy_d = trdy_q; devsel_d = devsel_q;
      mctl_oe_d = mctl_oe_q; tctl_oe_d = tctl_oe_q; cs_d = cs_q; bar_d = bar_q;
      cidx_d = cidx_q; tcfg_d = tcfg_q; twr_d = twr_q; req_d = req_q;
      done_d = 1'b0; abort_d = 1'b0; rdata_d = rdata_q; dcnt_d = dcnt_q;
      chkd_d = 1'b0; chkaddr_d = 1'b0;
      // parity driven one clock after each driven ad phase
      par_oe_d = ad_oe_q; par_d = even_par(ad_o_q, cbe_q);
      // par lags its phase by one clock, so check it against the held copy
      perr_d = chkd_q && (even_par(ad_prev_q, cbe_prev_q) != in_par)
               && cs_q[`PCISIG_CS_PERR_EN_BIT];
      sp_d = chkaddr_q && (even_par(ad_prev_q, cbe_prev_q) != in_par);
      // system error driven three clocks after the address phase
      serr_d = sp_q && cs_q[`PCISIG_CS_SERR_EN_BIT];
      case (st_q)
         pcisig_pkg::PCISIG_IDLE: begin
            // target decode of address phase
            if (bus.frame_b == 1'b0 && bus.irdy_b == 1'b1) begin
               chkaddr_d = 1'b1;
               tcfg_d = (in_cbe == `PCISIG_CMD_CFG_RD || in_cbe == `PCISIG_CMD_CFG_WR);
               twr_d  = in_cbe[0];
               cidx_d = in_ad[7:2];
               if ((tcfg_d && bus.idsel) ||
                   ((in_cbe == `PCISIG_CMD_MEM_RD || in_cbe == `PCISIG_CMD_MEM_WR) &&
                    ((in_ad & `PCISIG_BAR_MASK) == bar_q) && bar_q != 32'h00000000)) begin
                  devsel_d = 1'b0; tctl_oe_d = 1'b1; trdy_d = 1'b0;
                  st_d = pcisig_pkg::PCISIG_TDATA;
                  if (!in_cbe[0]) begin
                     ad_oe_d = 1'b1;
                     ad_o_d = (tcfg_d && in_ad[7:2] == `PCISIG_CFG_BAR) ? bar_q
                            : (tcfg_d ? cs_q : {16'h0000, ns_q});
                  end
               end
            end else if (mst_start) begin
               req_d = 1'b0;
               st_d = pcisig_pkg::PCISIG_MREQ;
            end
         end
         pcisig_pkg::PCISIG_MREQ: begin
            if (!bus.gnt_b && bus.frame_b && bus.irdy_b) begin
               frame_d = 1'b0; mctl_oe_d = 1'b1; irdy_d = 1'b1;
               ad_oe_d = 1'b1; ad_o_d = mst_addr;
               cbe_d = mst_write ? `PCISIG_CMD_MEM_WR : `PCISIG_CMD_MEM_RD;
               req_d = 1'b1; dcnt_d = 3'h0;
               st_d = pcisig_pkg::PCISIG_MADDR;
            end
         end
         pcisig_pkg::PCISIG_MADDR: begin
            // single data phase: frame rises as irdy falls
            cbe_d = 4'h0; ad_oe_d = mst_write; ad_o_d = mst_wdata;
            if (mst_ready) begin
               irdy_d = 1'b0; frame_d = 1'b1;
               st_d = pcisig_pkg::PCISIG_MDATA;
            end
         end
         pcisig_pkg::PCISIG_MDATA: begin
            dcnt_d = dcnt_q + 3'h1;
            if (dphase) begin
               chkd_d = !mst_write;
               rdata_d = in_ad; done_d = 1'b1;
               irdy_d = 1'b1;  // ready withdrawn right after completion
               st_d = pcisig_pkg::PCISIG_MTURN;
            end else if (!bus.stop_b ||
                         (bus.devsel_b && dcnt_q == 3'h4)) begin
               abort_d = 1'b1;
               irdy_d = 1'b1;
               st_d = pcisig_pkg::PCISIG_MTURN;
            end
         end
         pcisig_pkg::PCISIG_MTURN: begin
            irdy_d = 1'b1; frame_d = 1'b1; ad_oe_d = 1'b0;
            if (irdy_q) begin
               mctl_oe_d = 1'b0;
               st_d = pcisig_pkg::PCISIG_IDLE;
            end
         end
         pcisig_pkg::PCISIG_TDATA: begin
            if (dphase) begin
               chkd_d = twr_q;
               if (twr_q && tcfg_q && cidx_q == `PCISIG_CFG_CMDSTAT) begin
                  cs_d[15:0] = in_ad[15:0];
                  cs_d[31:30] = cs_d[31:30] & ~in_ad[31:30];
               end
               if (twr_q && tcfg_q && cidx_q == `PCISIG_CFG_BAR)
                  bar_d = in_ad & `PCISIG_BAR_MASK;
               trdy_d = 1'b1; devsel_d = 1'b1; ad_oe_d = 1'b0;
               st_d = pcisig_pkg::PCISIG_TTURN;
            end
         end
         pcisig_pkg::PCISIG_TTURN: begin
            tctl_oe_d = 1'b0;
            st_d = pcisig_pkg::PCISIG_IDLE;
         end
         default: st_d = pcisig_pkg::PCISIG_IDLE;
      endcase
      // hardware-set error flags win over a same-cycle write-1-clear
      if (perr_d) cs_d[`PCISIG_CS_DET_PERR_BIT] = 1'b1;
      if (sp_d) cs_d[`PCISIG_CS_DET_PERR_BIT] = 1'b1;
      if (serr_d) cs_d[`PCISIG_CS_SIG_SERR_BIT] = 1'b1;
   end

   // interrupt and pme next values; set wins over clear
   always_comb begin
      ns_d = (ns_q & ~status_clr) | status_set;
      int_d = |(ns_q & int_mask);
      pme_d = pme_s2_q;
   end

   // registers, all loaded with idle values by synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_q <= pcisig_pkg::PCISIG_IDLE; ad_o_q <= 32'h00000000; ad_oe_q <= 1'b0;
         cbe_q <= 4'hF; frame_q <= 1'b1; irdy_q <= 1'b1; trdy_q <= 1'b1;
         devsel_q <= 1'b1; mctl_oe_q <= 1'b0; tctl_oe_q <= 1'b0; par_oe_q <= 1'b0;
         par_q <= 1'b0; perr_q <= 1'b0; serr_q <= 1'b0; sp_q <= 1'b0; chkd_q <= 1'b0;
         chkaddr_q <= 1'b0; cs_q <= `PCISIG_CMDSTAT_RESET; bar_q <= `PCISIG_BAR_RESET;
         cidx_q <= 6'h00; tcfg_q <= 1'b0; twr_q <= 1'b0; req_q <= 1'b1;
         done_q <= 1'b0; abort_q <= 1'b0; rdata_q <= 32'h00000000; dcnt_q <= 3'h0;
         ns_q <= '0; int_q <= 1'b0; pme_q <= 1'b0; ad_prev_q <= 32'h00000000;
         cbe_prev_q <= 4'hF;
         pme_s1_q <= 1'b0; pme_s2_q <= 1'b0;
      end else begin
         st_q <= st_d; ad_o_q <= ad_o_d; ad_oe_q <= ad_oe_d; cbe_q <= cbe_d;
         frame_q <= frame_d; irdy_q <= irdy_d; trdy_q <= trdy_d; devsel_q <= devsel_d;
         mctl_oe_q <= mctl_oe_d; tctl_oe_q <= tctl_oe_d; par_oe_q <= par_oe_d;
         par_q <= par_d; perr_q <= perr_d; serr_q <= serr_d; sp_q <= sp_d;
         chkd_q <= chkd_d; chkaddr_q <= chkaddr_d; cs_q <= cs_d; bar_q <= bar_d;
         cidx_q <= cidx_d; tcfg_q <= tcfg_d; twr_q <= twr_d; req_q <= req_d;
         done_q <= done_d; abort_q <= abort_d; rdata_q <= rdata_d; dcnt_q <= dcnt_d;
         ns_q <= ns_d; int_q <= int_d; pme_q <= pme_d; ad_prev_q <= in_ad;
         cbe_prev_q <= in_cbe;
         pme_s1_q <= pme_event; pme_s2_q <= pme_s1_q;
      end
   end

   // pin drives straight from flip-flops
   assign bus.dev_ad_o = ad_o_q;       assign bus.dev_ad_oe = ad_oe_q;
   assign bus.dev_cbe_o = cbe_q;       assign bus.dev_cbe_oe = mctl_oe_q;
   assign bus.dev_par_o = par_q;       assign bus.dev_par_oe = par_oe_q;
   assign bus.dev_frame_o = frame_q;   assign bus.dev_frame_oe = mctl_oe_q;
   assign bus.dev_irdy_o = irdy_q;     assign bus.dev_irdy_oe = mctl_oe_q;
   assign bus.dev_trdy_o = trdy_q;     assign bus.dev_trdy_oe = tctl_oe_q;
   assign bus.dev_devsel_o = devsel_q; assign bus.dev_devsel_oe = tctl_oe_q;
   assign bus.dev_stop_o = 1'b1;       assign bus.dev_stop_oe = tctl_oe_q;
   assign bus.dev_perr_o = 1'b0;       assign bus.dev_perr_oe = perr_q;
   assign bus.dev_serr_o = 1'b0;       assign bus.dev_serr_oe = serr_q;
   assign bus.dev_int_oe = int_q;      assign bus.dev_pme_oe = pme_q;
   assign bus.req_b = req_q;
   assign mst_done = done_q;
   assign mst_abort = abort_q;
   assign mst_rdata = rdata_q;
   assign status_q_o = ns_q;
endmodule

// ---- shared/pcisig_consts.svh ----
// timing counts, field positions and reset values for the pci signalling pair
`ifndef PCISIG_CONSTS_SVH
`define PCISIG_CONSTS_SVH
`define PCISIG_SERR_DELAY      2
`define PCISIG_CMD_CFG_RD      4'hA
`define PCISIG_CMD_CFG_WR      4'hB
`define PCISIG_CMD_MEM_RD      4'h6
`define PCISIG_CMD_MEM_WR      4'h7
`define PCISIG_BAR_MASK        32'hFFFFFF00
`define PCISIG_BAR_RESET       32'h00000000
`define PCISIG_CMDSTAT_RESET   32'h00000000
`define PCISIG_CS_PERR_EN_BIT  6
`define PCISIG_CS_SERR_EN_BIT  8
`define PCISIG_CS_DET_PERR_BIT 31
`define PCISIG_CS_SIG_SERR_BIT 30
`define PCISIG_CFG_CMDSTAT     6'h01
`define PCISIG_CFG_BAR         6'h04
`define PCISIG_INT_WIDTH       16
`endif

// ---- shared/pcisig_pkg.sv ----
// types shared by both ends of the pci signalling pair
package pcisig_pkg;
   // device bus-interface states
   typedef enum logic [2:0] {
      PCISIG_IDLE, PCISIG_MREQ, PCISIG_MADDR, PCISIG_MDATA, PCISIG_MTURN,
      PCISIG_TDATA, PCISIG_TTURN
   } pcisig_state_type;
   // host-side states
   typedef enum logic [2:0] {
      PCISIG_H_IDLE, PCISIG_H_ADDR, PCISIG_H_DATA, PCISIG_H_TURN, PCISIG_H_TDATA
   } pcisig_hstate_type;
endpackage

// ---- shared/pcisig_if.sv ----
// bus wires joining the nic device end and the host end
`timescale 1ns/1ps
interface pcisig_if (
   input wire logic clk
);
   // per-party drives, enables high while driving
   logic [31:0] dev_ad_o,  host_ad_o;
   logic        dev_ad_oe, host_ad_oe;
   logic [3:0]  dev_cbe_o, host_cbe_o;
   logic        dev_cbe_oe, host_cbe_oe;
   logic        dev_par_o, host_par_o, dev_par_oe, host_par_oe;
   logic        dev_frame_o, host_frame_o, dev_frame_oe, host_frame_oe;
   logic        dev_irdy_o, host_irdy_o, dev_irdy_oe, host_irdy_oe;
   logic        dev_trdy_o, host_trdy_o, dev_trdy_oe, host_trdy_oe;
   logic        dev_devsel_o, host_devsel_o, dev_devsel_oe, host_devsel_oe;
   logic        dev_stop_o, host_stop_o, dev_stop_oe, host_stop_oe;
   logic        dev_perr_o, dev_perr_oe, dev_serr_o, dev_serr_oe;
   logic        dev_int_oe, dev_pme_oe;    // open drain, low while enabled
   logic        req_b, gnt_b, idsel;
   // resolved wire levels (control lines pulled up on idle, ad and par low)
   logic [31:0] ad;
   logic [3:0]  cbe_b;
   logic        par, frame_b, irdy_b, trdy_b, devsel_b, stop_b, perr_b, serr_b;
   logic        int_b, pme_b;
   assign ad       = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : 32'h00000000);
   assign cbe_b    = dev_cbe_oe ? dev_cbe_o : (host_cbe_oe ? host_cbe_o : 4'hF);
   assign par      = dev_par_oe ? dev_par_o : (host_par_oe ? host_par_o : 1'b0);
   assign frame_b  = dev_frame_oe ? dev_frame_o : (host_frame_oe ? host_frame_o : 1'b1);
   assign irdy_b   = dev_irdy_oe ? dev_irdy_o : (host_irdy_oe ? host_irdy_o : 1'b1);
   assign trdy_b   = dev_trdy_oe ? dev_trdy_o : (host_trdy_oe ? host_trdy_o : 1'b1);
   assign devsel_b = dev_devsel_oe ? dev_devsel_o
                   : (host_devsel_oe ? host_devsel_o : 1'b1);
   assign stop_b   = dev_stop_oe ? dev_stop_o : (host_stop_oe ? host_stop_o : 1'b1);
   assign perr_b   = dev_perr_oe ? dev_perr_o : 1'b1;
   assign serr_b   = dev_serr_oe ? dev_serr_o : 1'b1;
   assign int_b    = dev_int_oe ? 1'b0 : 1'b1;
   assign pme_b    = dev_pme_oe ? 1'b0 : 1'b1;
   // nic end
   modport dev (
      input  ad, cbe_b, par, frame_b, irdy_b, trdy_b, devsel_b, stop_b, gnt_b, idsel,
      output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_par_o, dev_par_oe,
      output dev_frame_o, dev_frame_oe, dev_irdy_o, dev_irdy_oe, dev_trdy_o, dev_trdy_oe,
      output dev_devsel_o, dev_devsel_oe, dev_stop_o, dev_stop_oe,
      output dev_perr_o, dev_perr_oe, dev_serr_o, dev_serr_oe, dev_int_oe, dev_pme_oe,
      output req_b
   );
   // host, arbiter and other agents
   modport host (
      input  ad, cbe_b, par, frame_b, irdy_b, trdy_b, devsel_b, stop_b, perr_b, serr_b,
      input  int_b, pme_b, req_b,
      output host_ad_o, host_ad_oe, host_cbe_o, host_cbe_oe, host_par_o, host_par_oe,
      output host_frame_o, host_frame_oe, host_irdy_o, host_irdy_oe,
      output host_trdy_o, host_trdy_oe, host_devsel_o, host_devsel_oe,
      output host_stop_o, host_stop_oe, gnt_b, idsel
   );
endinterface

// ---- verilog/pcisig_host.sv ----
// host end: arbiter grant and single-phase initiator toward the nic
`timescale 1ns/1ps
`include "pcisig_consts.svh"
module pcisig_host (
   input  wire logic        clk,        // pci clock
   input  wire logic        rst_b,      // sync reset, low active
   pcisig_if.host           bus,        // pci wires
   input  wire logic        h_start,    // pulse: begin host cycle
   input  wire logic [3:0]  h_cmd,      // bus command
   input  wire logic [31:0] h_addr,     // address
   input  wire logic [31:0] h_wdata,    // write data
   input  wire logic        h_cfg,      // raise idsel for config
   output logic             h_done,     // pulse: cycle complete
   output logic             h_abort,    // pulse: no devsel
   output logic [31:0]      h_rdata     // read data
);
   pcisig_pkg::pcisig_hstate_type st_q, st_d;
   logic [31:0] ad_q, ad_d, rd_q, rd_d;
   logic        adoe_q, adoe_d, oe_q, oe_d, fr_q, fr_d, ir_q, ir_d, id_q, id_d;
   logic [3:0]  cbe_q, cbe_d;
   logic        par_q, par_d, paroe_q, paroe_d, gnt_q, gnt_d;
   logic        trdy_q, trdy_d, dvs_q, dvs_d, toe_q, toe_d, dn_q, dn_d, ab_q, ab_d;
   logic [2:0]  cnt_q, cnt_d;
   logic        wr;

   assign wr = h_cmd[0];

   // initiator, arbiter and simple target-for-nic next values
   always_comb begin
      st_d = st_q; ad_d = ad_q; rd_d = rd_q; adoe_d = adoe_q; oe_d = oe_q;
      fr_d = fr_q; ir_d = ir_q; id_d = id_q; cbe_d = cbe_q; cnt_d = cnt_q;
      trdy_d = trdy_q; dvs_d = dvs_q; toe_d = toe_q; dn_d = 1'b0; ab_d = 1'b0;
      par_d = ^{ad_q, cbe_q};
      paroe_d = adoe_q;
      gnt_d = !(!bus.req_b && st_q == pcisig_pkg::PCISIG_H_IDLE);
      case (st_q)
         pcisig_pkg::PCISIG_H_IDLE: begin
            if (h_start && bus.req_b && gnt_q) begin
               fr_d = 1'b0; oe_d = 1'b1; adoe_d = 1'b1; ad_d = h_addr; cbe_d = h_cmd;
               id_d = h_cfg;
               cnt_d = 3'h0; st_d = pcisig_pkg::PCISIG_H_ADDR;
            end else if (!bus.frame_b && bus.irdy_b && !gnt_q && !bus.ad[31]) begin
               // nic as master: host memory is the lower half, upper half unclaimed
               dvs_d = 1'b0; trdy_d = 1'b0; toe_d = 1'b1;
               st_d = pcisig_pkg::PCISIG_H_TDATA;
            end
         end
         pcisig_pkg::PCISIG_H_ADDR: begin
            id_d = 1'b0; cbe_d = 4'h0; adoe_d = wr; ad_d = h_wdata;
            ir_d = 1'b0; fr_d = 1'b1;
            st_d = pcisig_pkg::PCISIG_H_DATA;
         end
         pcisig_pkg::PCISIG_H_DATA: begin
            cnt_d = cnt_q + 3'h1;
            if (!bus.irdy_b && !bus.trdy_b) begin
               ir_d = 1'b1;  // ready withdrawn right after completion
               rd_d = bus.ad; dn_d = 1'b1; st_d = pcisig_pkg::PCISIG_H_TURN;
            end else if (!bus.stop_b || (bus.devsel_b && cnt_q == 3'h4)) begin
               ir_d = 1'b1;
               ab_d = 1'b1; st_d = pcisig_pkg::PCISIG_H_TURN;
            end
         end
         pcisig_pkg::PCISIG_H_TURN: begin
            ir_d = 1'b1; adoe_d = 1'b0;
            if (ir_q) begin
               oe_d = 1'b0; st_d = pcisig_pkg::PCISIG_H_IDLE;
            end
         end
         pcisig_pkg::PCISIG_H_TDATA: begin
            if (!bus.irdy_b && !bus.trdy_b) begin
               trdy_d = 1'b1; dvs_d = 1'b1;
            end
            if (trdy_q && dvs_q) begin
               toe_d = 1'b0; st_d = pcisig_pkg::PCISIG_H_IDLE;
            end
         end
         default: st_d = pcisig_pkg::PCISIG_H_IDLE;
      endcase
   end

   // registers with synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_q <= pcisig_pkg::PCISIG_H_IDLE; ad_q <= 32'h00000000; rd_q <= 32'h00000000;
         adoe_q <= 1'b0; oe_q <= 1'b0; fr_q <= 1'b1; ir_q <= 1'b1; id_q <= 1'b0;
         cbe_q <= 4'hF; cnt_q <= 3'h0; par_q <= 1'b0; paroe_q <= 1'b0; gnt_q <= 1'b1;
         trdy_q <= 1'b1; dvs_q <= 1'b1; toe_q <= 1'b0; dn_q <= 1'b0; ab_q <= 1'b0;
      end else begin
         st_q <= st_d; ad_q <= ad_d; rd_q <= rd_d; adoe_q <= adoe_d; oe_q <= oe_d;
         fr_q <= fr_d; ir_q <= ir_d; id_q <= id_d; cbe_q <= cbe_d; cnt_q <= cnt_d;
         par_q <= par_d; paroe_q <= paroe_d; gnt_q <= gnt_d; trdy_q <= trdy_d;
         dvs_q <= dvs_d; toe_q <= toe_d; dn_q <= dn_d; ab_q <= ab_d;
      end
   end

   assign bus.host_ad_o = ad_q;       assign bus.host_ad_oe = adoe_q;
   assign bus.host_cbe_o = cbe_q;     assign bus.host_cbe_oe = oe_q;
   assign bus.host_par_o = par_q;     assign bus.host_par_oe = paroe_q;
   assign bus.host_frame_o = fr_q;    assign bus.host_frame_oe = oe_q;
   assign bus.host_irdy_o = ir_q;     assign bus.host_irdy_oe = oe_q;
   assign bus.host_trdy_o = trdy_q;   assign bus.host_trdy_oe = toe_q;
   assign bus.host_devsel_o = dvs_q;  assign bus.host_devsel_oe = toe_q;
   assign bus.host_stop_o = 1'b1;     assign bus.host_stop_oe = toe_q;
   assign bus.gnt_b = gnt_q;
   assign bus.idsel = id_q;
   assign h_done = dn_q;
   assign h_abort = ab_q;
   assign h_rdata = rd_q;
endmodule

// ---- test/pcisig_checker.sv ----
// concurrent checks on the pci wires between the nic end and the host end
`timescale 1ns/1ps
module pcisig_checker (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [31:0] ad,
   input wire logic [3:0]  cbe_b,
   input wire logic        par,
   input wire logic        frame_b,
   input wire logic        irdy_b,
   input wire logic        trdy_b,
   input wire logic        devsel_b,
   input wire logic        serr_b,
   input wire logic        req_b,
   input wire logic        gnt_b,
   input wire logic        idsel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire addr_ph = !frame_b && irdy_b;    // address phase on the bus
   wire cfg_cmd = cbe_b[3:1] == 3'h5;    // config read or write command
   property p_grant; $fell(frame_b) && $past(req_b) == 1'b0 |-> $past(gnt_b) == 1'b0; endproperty
   a_grant: assert property (p_grant) else $error("frame started without grant");
   property p_req; $fell(req_b) |-> ##[1:6] $fell(frame_b); endproperty
   a_req: assert property (p_req) else $error("request not followed by frame");
   property p_frame; $fell(frame_b) |=> frame_b && !irdy_b; endproperty
   a_frame: assert property (p_frame) else $error("frame or ready wrong");
   property p_claim; addr_ph && idsel && cfg_cmd |=> !devsel_b && !trdy_b; endproperty
   a_claim: assert property (p_claim) else $error("config cycle not claimed");
   property p_noclaim; addr_ph && !idsel && cfg_cmd |=> devsel_b; endproperty
   a_noclaim: assert property (p_noclaim) else $error("claimed without select");
   property p_done; !irdy_b && !trdy_b |=> irdy_b && frame_b; endproperty
   a_done: assert property (p_done) else $error("phase not ended");
   property p_serr; $fell(serr_b) |-> $past(addr_ph, 3) ##1 serr_b; endproperty
   a_serr: assert property (p_serr) else $error("system error timing wrong");
   property p_par; addr_ph |=> par == (^$past(ad) ^ ^$past(cbe_b)); endproperty
   a_par: assert property (p_par) else $error("address parity not even");
   c_done: cover property (!irdy_b && !trdy_b);
   c_claim: cover property ($fell(devsel_b));
   c_master: cover property ($fell(req_b) ##[1:6] $fell(frame_b));
endmodule

// ---- test/pci_bus_signaling_test.sv ----
// self-checking bench joining the nic end and the host end over the pci wires
`timescale 1ns/1ps
`include "pcisig_consts.svh"
module pci_bus_signaling_test;
   logic        clk, rst_b, mst_start, mst_write, mst_ready, pme_event, mst_done, mst_abort;
   logic        h_start, h_cfg, h_done, h_abort, hab;
   logic [31:0] mst_addr, mst_wdata, mst_rdata, h_addr, h_wdata, h_rdata;
   logic [15:0] status_set, status_clr, int_mask, status_q_o;
   logic [3:0]  h_cmd;
   int          bad_count, checks_done;
   pcisig_if bus (.clk(clk));
   pcisig_dev pcisig_dev_i (.clk(clk), .rst_b(rst_b), .bus(bus), .mst_start(mst_start),
      .mst_write(mst_write), .mst_addr(mst_addr), .mst_wdata(mst_wdata),
      .mst_ready(mst_ready), .status_set(status_set), .status_clr(status_clr),
      .int_mask(int_mask), .pme_event(pme_event), .mst_done(mst_done),
      .mst_abort(mst_abort), .mst_rdata(mst_rdata), .status_q_o(status_q_o));
   pcisig_host pcisig_host_i (.clk(clk), .rst_b(rst_b), .bus(bus), .h_start(h_start),
      .h_cmd(h_cmd), .h_addr(h_addr), .h_wdata(h_wdata), .h_cfg(h_cfg),
      .h_done(h_done), .h_abort(h_abort), .h_rdata(h_rdata));
   pcisig_checker pcisig_checker_i (.clk(clk), .rst_b(rst_b), .ad(bus.ad),
      .cbe_b(bus.cbe_b), .par(bus.par), .frame_b(bus.frame_b), .irdy_b(bus.irdy_b),
      .trdy_b(bus.trdy_b), .devsel_b(bus.devsel_b), .serr_b(bus.serr_b),
      .req_b(bus.req_b), .gnt_b(bus.gnt_b), .idsel(bus.idsel));
   // free-running pci clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare one value, count and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // verdict and end of run
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // step n falling edges
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one host cycle, bounded wait for done or abort
   task automatic hcyc(input logic [3:0] c, input logic [31:0] a, input logic s);
      int i;
      h_cmd = c;
      h_addr = a;
      h_cfg = s;
      h_start = 1'b1;
      cyc(1);
      h_start = 1'b0;
      for (i = 0; i < 20 && h_done !== 1'b1 && h_abort !== 1'b1; i++) cyc(1);
      if (i == 20) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, i, 19);
         wrap_up();
      end
      hab = h_abort;
      cyc(2);
   endtask
   // base address write and read back, then an unselected config read
   task automatic t_config;
      h_wdata = 32'h00012300;
      hcyc(`PCISIG_CMD_CFG_WR, 32'h00000010, 1'b1);
      hcyc(`PCISIG_CMD_CFG_RD, 32'h00000010, 1'b1);
      chk(h_rdata, 32'h00012300);
      hcyc(`PCISIG_CMD_CFG_RD, 32'h00000010, 1'b0);
      chk(hab, 32'h1);
      $display("test config done");
   endtask
   // masked and unmasked status, memory read of status, clearing
   task automatic t_intr;
      int_mask = 16'h0001;
      status_set = 16'h0003;
      cyc(1);
      status_set = 16'h0000;
      cyc(2);
      chk(bus.int_b, 32'h0);
      hcyc(`PCISIG_CMD_MEM_RD, 32'h00012300, 1'b0);
      chk(h_rdata, 32'h00000003);
      status_clr = 16'h0001;
      cyc(1);
      status_clr = 16'h0000;
      cyc(2);
      chk(bus.int_b, 32'h1);
      int_mask = 16'h0002;
      cyc(2);
      chk(bus.int_b, 32'h0);
      $display("test interrupt done");
   endtask
   // one nic master write, bounded wait, then done or abort as expected
   task automatic mcyc(input logic [31:0] a, input logic ab);
      int i;
      mst_addr = a;
      mst_start = 1'b1;
      cyc(1);
      mst_start = 1'b0;
      for (i = 0; i < 30 && mst_abort !== 1'b1 && mst_done !== 1'b1; i++) cyc(1);
      if (i == 30) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, i, 29);
         wrap_up();
      end
      chk(mst_abort, {31'h0, ab});
      chk(mst_done, {31'h0, !ab});
      cyc(3);
   endtask
   // claimed master write, master write nobody claims, then a power event
   task automatic t_master;
      mst_wdata = 32'h0000BEEF;
      mcyc(32'h00001000, 1'b0);
      mcyc(32'h80000000, 1'b1);
      pme_event = 1'b1;
      cyc(4);
      chk(bus.pme_b, 32'h0);
      pme_event = 1'b0;
      cyc(4);
      chk(bus.pme_b, 32'h1);
      $display("test master done");
   endtask
   // reset mid-run clears status and releases the interrupt
   task automatic t_reset;
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      cyc(1);
      chk(bus.int_b, 32'h1);
      chk(status_q_o, 32'h0);
      $display("test reset done");
   endtask
   // main sequence
   initial begin
      {rst_b, mst_start, mst_ready, pme_event, h_start, h_cfg, hab} = 7'h10;
      {mst_write, mst_addr, mst_wdata, h_addr, h_wdata, h_cmd} = {1'b1, 100'h0, 32'h0};
      {status_set, status_clr, int_mask} = 48'h0;
      bad_count = 0;
      checks_done = 0;
      cyc(10);
      rst_b = 1'b1;
      cyc(1);
      t_config();
      t_intr();
      t_master();
      t_reset();
      wrap_up();
   end
endmodule
